/* ccx_pkg.sv */
// What this block does
// - Two-word direct call; word one low target bits, word two upper bits.
// - Direct call target spans zero to 8388606; lowest target bit always zero.
// - Direct call pushes 24-bit return address, call address plus four.
// - Newer cores store stack-frame-active flag in bit 0 of low word.
// - Newer cores clear stack-frame-active flag after stacking; only status change made.
// - Indirect call opcode fixed; low four bits select target register.
// - Indirect call pushes 24-bit return address, call address plus two.
// - Indirect call loads register bits 15:1, clears PC bits 22:16.
// - Indirect call reach limited to first 32K instruction locations.
// - Long indirect call takes even register W0..W12 plus odd partner.
// - Long call: partner low seven bits to PC 22:16, even to 15:0.
// - Long call keeps PC bit 23, ignores partner high bits, PC0 zero.
// - Clear-file decode: byte/word bit, destination bit, 13-bit address.
// - Destination bit 0 clears default register, 1 clears file register.
// - Byte/word bit 0 gives word operation, 1 gives byte operation.
// - Default working register is W0.
// - Clear-register decode: 3-bit mode, 4-bit register, six addressing modes.
package ccx_pkg;
    localparam logic [7:0] CCX_OP_CALL = 8'h02;
    localparam logic [7:0] CCX_OP_CALLW = 8'h01;
    localparam logic [7:0] CCX_OP_CLRF_HI = 8'hEF;
    localparam logic [7:0] CCX_OP_CLRW_HI = 8'hEB;
    localparam logic [23:0] CCX_RET_DIRECT = 24'h000004;
    localparam logic [23:0] CCX_RET_INDIRECT = 24'h000002;
    localparam logic [15:0] CCX_SP_STEP = 16'h0002;
    localparam logic [3:0] CCX_DEFAULT_WORKING_REGISTER_IDX = 4'h0;
    localparam logic [3:0] CCX_SP_IDX = 4'hF;
    localparam logic [23:0] CCX_NOP_WORD = 24'h000000;
    localparam int CCX_CALL_CYC_NEW = 4;
    localparam int CCX_CALL_CYC_OLD = 2;
    localparam logic [2:0] CCX_AM_DIRECT = 3'h0;
    localparam logic [2:0] CCX_AM_IND = 3'h1;
    localparam logic [2:0] CCX_AM_POSTDEC = 3'h2;
    localparam logic [2:0] CCX_AM_POSTINC = 3'h3;
    localparam logic [2:0] CCX_AM_PREDEC = 3'h4;
    localparam logic [2:0] CCX_AM_PREINC = 3'h5;
    typedef enum logic [2:0] {
        CCX_IDLE = 3'b000,
        CCX_PUSH_LO = 3'b001,
        CCX_PUSH_HI = 3'b011,
        CCX_LOAD = 3'b010,
        CCX_WAIT2 = 3'b110,
        CCX_FETCH2 = 3'b100
    } ccx_state_e;
endpackage : ccx_pkg

/* ccx_byte_merge.sv */
`timescale 1ns/1ps
// Zeroes a word or one byte of it, other byte kept
module ccx_byte_merge (
    input wire logic [15:0] old_i,
    input wire logic byte_i,
    input wire logic odd_i,
    output logic [15:0] new_o
);
    always_comb begin
        if (!byte_i) begin
            new_o = 16'h0000;
        end else if (odd_i) begin
            new_o = {8'h00, old_i[7:0]};
        end else begin
            new_o = {old_i[15:8], 8'h00};
        end
    end
endmodule : ccx_byte_merge

/* ccx_call_clear.sv */
`timescale 1ns/1ps
module ccx_call_clear
    import ccx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic new_core_i,
    input wire logic instr_valid_i,
    input wire logic [23:0] instr_i,
    input wire logic [23:0] instr2_i,
    input wire logic instr2_valid_i,
    input wire logic [23:0] pc_i,
    input wire logic sfa_i,
    output logic [3:0] default_working_register_rd_a_o,
    output logic [3:0] default_working_register_rd_b_o,
    input wire logic [15:0] default_working_register_a_i,
    input wire logic [15:0] default_working_register_b_i,
    input wire logic [15:0] sp_i,
    input wire logic [15:0] mem_rd_i,
    output logic busy_o,
    output logic pc_load_o,
    output logic [23:0] pc_o,
    output logic sfa_clr_o,
    output logic nop_inject_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    output logic default_working_register_we_o,
    output logic [3:0] default_working_register_wa_o,
    output logic [15:0] default_working_register_wdata_o
);
    localparam logic [1:0] K_DIR = 2'd1;
    localparam logic [1:0] K_IND = 2'd2;
    localparam logic [1:0] K_LONG = 2'd3;

    function automatic logic [1:0] call_kind(input logic [23:0] w);
        if (w[23:16] == CCX_OP_CALL) begin
            call_kind = K_DIR;
        end else if (w[23:16] == CCX_OP_CALLW && w[15:4] == 12'h000) begin
            call_kind = K_IND;
        end else if (w[23:16] == CCX_OP_CALLW && w[15] && w[10:4] == 7'h00
                     && !w[0] && w[3:0] <= 4'hC
                     && w[14:11] == (w[3:0] | 4'h1)) begin
            call_kind = K_LONG;
        end else begin
            call_kind = 2'd0;
        end
    endfunction : call_kind

    ccx_state_e st_r, st_nxt;
    logic [1:0] kind_r, kind_nxt;
    logic [23:0] ret_r, ret_nxt;
    logic [23:0] tgt_r, tgt_nxt;
    logic sfa_r, sfa_nxt;
    logic [1:0] dk;
    logic [15:0] merged;
    logic clrf, clrw, clr_byte;
    logic [2:0] am;
    logic [15:0] eff_addr;
    logic busy_nxt, pcl_nxt, sfac_nxt, nop_nxt, mwe_nxt, wwe_nxt;
    logic [23:0] pc_nxt;
    logic [15:0] maddr_nxt, mwd_nxt, wwd_nxt;
    logic [3:0] wwa_nxt;

    assign dk = instr_valid_i ? call_kind(instr_i) : 2'd0;
    assign clrf = instr_valid_i && st_r == CCX_IDLE
                  && instr_i[23:16] == CCX_OP_CLRF_HI && !instr_i[15];
    assign clrw = instr_valid_i && st_r == CCX_IDLE
                  && instr_i[23:16] == CCX_OP_CLRW_HI && !instr_i[15]
                  && instr_i[6:0] == 7'h00;
    assign clr_byte = instr_i[14];
    assign am = instr_i[13:11];

    // Read port A: operand register; port B: long call partner
    always_comb begin
        default_working_register_rd_a_o = instr_i[3:0];
        default_working_register_rd_b_o = instr_i[14:11];
        if (clrw) begin
            default_working_register_rd_a_o = instr_i[10:7];
        end else if (clrf && !instr_i[13]) begin
            default_working_register_rd_a_o = CCX_DEFAULT_WORKING_REGISTER_IDX;
        end
    end

    always_comb begin
        case (am)
            CCX_AM_PREDEC: eff_addr = default_working_register_a_i - (clr_byte ? 16'h0001 : 16'h0002);
            CCX_AM_PREINC: eff_addr = default_working_register_a_i + (clr_byte ? 16'h0001 : 16'h0002);
            default: eff_addr = default_working_register_a_i;
        endcase
    end

    // Byte merge uses data read at the addressed location
    ccx_byte_merge u_merge (
        .old_i((clrw && am == CCX_AM_DIRECT) || (clrf && !instr_i[13])
               ? default_working_register_a_i : mem_rd_i),
        .byte_i(clr_byte),
        .odd_i(clrw ? (am == CCX_AM_DIRECT ? 1'b0 : eff_addr[0])
                    : (instr_i[13] ? instr_i[0] : 1'b0)),
        .new_o(merged)
    );

    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        ret_nxt = ret_r;
        tgt_nxt = tgt_r;
        sfa_nxt = sfa_r;
        busy_nxt = 1'b0;
        pcl_nxt = 1'b0;
        pc_nxt = pc_o;
        sfac_nxt = 1'b0;
        nop_nxt = 1'b0;
        mwe_nxt = 1'b0;
        maddr_nxt = mem_addr_o;
        mwd_nxt = mem_wdata_o;
        wwe_nxt = 1'b0;
        wwa_nxt = default_working_register_wa_o;
        wwd_nxt = default_working_register_wdata_o;
        case (st_r)
            CCX_IDLE: begin
                if (dk != 2'd0) begin
                    kind_nxt = dk;
                    sfa_nxt = sfa_i;
                    busy_nxt = 1'b1;
                    nop_nxt = 1'b1;
                    if (dk == K_DIR) begin
                        ret_nxt = pc_i + CCX_RET_DIRECT;
                        tgt_nxt = {1'b0, 7'h00, instr_i[15:1], 1'b0};
                        st_nxt = CCX_FETCH2;
                    end else begin
                        ret_nxt = pc_i + CCX_RET_INDIRECT;
                        if (dk == K_IND) begin
                            tgt_nxt = {pc_i[23], 7'h00, default_working_register_a_i[15:1],
                                       1'b0};
                        end else begin
                            tgt_nxt = {pc_i[23], default_working_register_b_i[6:0],
                                       default_working_register_a_i[15:1], 1'b0};
                        end
                        st_nxt = CCX_PUSH_LO;
                    end
                end else if (clrf) begin
                    if (instr_i[13]) begin
                        mwe_nxt = 1'b1;
                        maddr_nxt = {3'h0, instr_i[12:1],
                                     clr_byte & instr_i[0]};
                        mwd_nxt = merged;
                    end else begin
                        wwe_nxt = 1'b1;
                        wwa_nxt = CCX_DEFAULT_WORKING_REGISTER_IDX;
                        wwd_nxt = merged;
                    end
                end else if (clrw) begin
                    if (am == CCX_AM_DIRECT) begin
                        wwe_nxt = 1'b1;
                        wwa_nxt = instr_i[10:7];
                        wwd_nxt = merged;
                    end else begin
                        mwe_nxt = 1'b1;
                        maddr_nxt = eff_addr;
                        mwd_nxt = merged;
                        if (am != CCX_AM_IND) begin
                            wwe_nxt = 1'b1;
                            wwa_nxt = instr_i[10:7];
                            case (am)
                                CCX_AM_POSTINC: wwd_nxt = default_working_register_a_i
                                    + (clr_byte ? 16'h0001 : 16'h0002);
                                CCX_AM_POSTDEC: wwd_nxt = default_working_register_a_i
                                    - (clr_byte ? 16'h0001 : 16'h0002);
                                default: wwd_nxt = eff_addr;
                            endcase
                        end
                    end
                end
            end
            CCX_FETCH2: begin
                busy_nxt = 1'b1;
                nop_nxt = 1'b1;
                if (instr2_valid_i) begin
                    tgt_nxt = {1'b0, instr2_i[6:0], tgt_r[15:0]};
                    st_nxt = CCX_PUSH_LO;
                end
            end
            CCX_PUSH_LO: begin
                busy_nxt = 1'b1;
                mwe_nxt = 1'b1;
                maddr_nxt = sp_i;
                mwd_nxt = {ret_r[15:1], new_core_i ? sfa_r : ret_r[0]};
                wwe_nxt = 1'b1;
                wwa_nxt = CCX_SP_IDX;
                wwd_nxt = sp_i + CCX_SP_STEP;
                st_nxt = CCX_PUSH_HI;
            end
            CCX_PUSH_HI: begin
                busy_nxt = 1'b1;
                mwe_nxt = 1'b1;
                // Low-word pointer update lands only at the next edge
                maddr_nxt = sp_i + CCX_SP_STEP;
                mwd_nxt = {8'h00, ret_r[23:16]};
                wwe_nxt = 1'b1;
                wwa_nxt = CCX_SP_IDX;
                wwd_nxt = sp_i + CCX_SP_STEP + CCX_SP_STEP;
                sfac_nxt = new_core_i;
                // Direct call already spent a cycle fetching word two
                if (!new_core_i) begin
                    // Older core loads while the high byte is written
                    busy_nxt = 1'b0;
                    pcl_nxt = 1'b1;
                    pc_nxt = tgt_r;
                    st_nxt = CCX_IDLE;
                end else if (kind_r == K_DIR) begin
                    st_nxt = CCX_LOAD;
                end else begin
                    st_nxt = CCX_WAIT2;
                end
            end
            CCX_WAIT2: begin
                busy_nxt = 1'b1;
                st_nxt = CCX_LOAD;
            end
            CCX_LOAD: begin
                pcl_nxt = 1'b1;
                pc_nxt = tgt_r;
                st_nxt = CCX_IDLE;
            end
            default: st_nxt = CCX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= CCX_IDLE;
            kind_r <= 2'd0;
            ret_r <= 24'h000000;
            tgt_r <= 24'h000000;
            sfa_r <= 1'b0;
            busy_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_o <= 24'h000000;
            sfa_clr_o <= 1'b0;
            nop_inject_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 16'h0000;
            default_working_register_we_o <= 1'b0;
            default_working_register_wa_o <= 4'h0;
            default_working_register_wdata_o <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            ret_r <= ret_nxt;
            tgt_r <= tgt_nxt;
            sfa_r <= sfa_nxt;
            busy_o <= busy_nxt;
            pc_load_o <= pcl_nxt;
            pc_o <= pc_nxt;
            sfa_clr_o <= sfac_nxt;
            nop_inject_o <= nop_nxt;
            mem_we_o <= mwe_nxt;
            mem_addr_o <= maddr_nxt;
            mem_wdata_o <= mwd_nxt;
            default_working_register_we_o <= wwe_nxt;
            default_working_register_wa_o <= wwa_nxt;
            default_working_register_wdata_o <= wwd_nxt;
        end
    end

    // Cycles since the call was taken, for checks only
    logic [3:0] age_r;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || st_r == CCX_IDLE) begin
            age_r <= 4'h0;
        end else begin
            age_r <= age_r + 4'h1;
        end
    end

    a_ind_cycles: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r == CCX_IDLE && dk == K_IND && new_core_i
        |-> ##5 pc_load_o) else $error("indirect call not four cycles");
    a_old_cycles: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r == CCX_IDLE && dk == K_IND && !new_core_i
        |-> ##3 pc_load_o) else $error("old indirect call timing wrong");
    a_ind_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pc_load_o && kind_r == K_IND |-> pc_o[22:16] == 7'h00 && !pc_o[0])
        else $error("indirect target out of reach");
    a_pc0_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pc_load_o |-> !pc_o[0]) else $error("target bit 0 set");
    a_push_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r == CCX_PUSH_LO |=> mem_we_o ##1 mem_we_o
        && mem_wdata_o[15:8] == 8'h00) else $error("push order wrong");
    a_sp_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r == CCX_PUSH_LO |=> default_working_register_we_o && default_working_register_wa_o == CCX_SP_IDX
        && default_working_register_wdata_o == $past(sp_i) + CCX_SP_STEP)
        else $error("stack pointer step wrong");
    a_sfa_after: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfa_clr_o |-> $past(mem_we_o) && mem_we_o)
        else $error("flag cleared before stacking");
    a_ret_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r == CCX_IDLE && dk == K_IND |=> ret_r == $past(pc_i) + 24'h2)
        else $error("indirect return address wrong");
    a_clr_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clrf && dk == 2'd0 |=> (mem_we_o || default_working_register_we_o) && !busy_o
        && !sfa_clr_o) else $error("clear not single cycle");
    a_age_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        age_r < 4'h8) else $error("call sequence hung");
endmodule : ccx_call_clear

/* ccx_far_model.sv */
`timescale 1ns/1ps
// Register file and data memory as the core datapath would present them
module ccx_far_model (
    input wire logic clk_i,
    input wire logic [23:0] instr_i,
    input wire logic [3:0] default_working_register_rd_a_i,
    input wire logic [3:0] default_working_register_rd_b_i,
    output logic [15:0] default_working_register_a_o,
    output logic [15:0] default_working_register_b_o,
    output logic [15:0] sp_o,
    output logic [15:0] mem_rd_o,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic default_working_register_we_i,
    input wire logic [3:0] default_working_register_wa_i,
    input wire logic [15:0] default_working_register_wdata_i
);
    logic [15:0] regs [16];
    logic [15:0] mem [32768];
    logic [15:0] rd_addr;
    logic [15:0] step;
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 16'hFFFF;
        for (int i = 0; i < 16; i++) regs[i] = 16'h0000;
    end
    assign default_working_register_a_o = regs[default_working_register_rd_a_i];
    assign default_working_register_b_o = regs[default_working_register_rd_b_i];
    assign sp_o = regs[15];
    // Read port follows the clear's effective address in the take cycle
    always_comb begin
        step = instr_i[14] ? 16'h0001 : 16'h0002;
        rd_addr = regs[instr_i[10:7]];
        if (instr_i[23:16] == 8'hEF) rd_addr = {3'h0, instr_i[12:0]};
        else if (instr_i[13:11] == 3'h4) rd_addr = rd_addr - step;
        else if (instr_i[13:11] == 3'h5) rd_addr = rd_addr + step;
        mem_rd_o = mem[rd_addr[15:1]];
    end
    // Plain always: the bench also preloads these arrays
    always @(posedge clk_i) begin
        if (mem_we_i) mem[mem_addr_i[15:1]] <= mem_wdata_i;
        if (default_working_register_we_i) regs[default_working_register_wa_i] <= default_working_register_wdata_i;
    end
endmodule : ccx_far_model

/* call_and_clear_execute_test.sv */
`timescale 1ns/1ps
module call_and_clear_execute_test;
    import ccx_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic new_core_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic instr2_valid_i = 1'b0;
    logic sfa_i = 1'b0;
    logic [23:0] instr_i = 24'h000000;
    logic [23:0] instr2_i = 24'h000000;
    logic [23:0] pc_i = 24'h000000;
    logic [3:0] rd_a, rd_b, wa;
    logic [15:0] ra, rb, sp, mrd, maddr, mwd, wwd;
    logic busy_o, pc_load_o, sfa_clr_o, nop_inject_o, mwe, wwe;
    logic [23:0] pc_o;
    int err_total = 0;
    int num_checks = 0;
    always #25 clk_i = ~clk_i;
    ccx_call_clear ccx_call_clear_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .new_core_i(new_core_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .instr2_i(instr2_i), .instr2_valid_i(instr2_valid_i),
        .pc_i(pc_i), .sfa_i(sfa_i), .default_working_register_rd_a_o(rd_a), .default_working_register_rd_b_o(rd_b),
        .default_working_register_a_i(ra), .default_working_register_b_i(rb), .sp_i(sp), .mem_rd_i(mrd),
        .busy_o(busy_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
        .sfa_clr_o(sfa_clr_o), .nop_inject_o(nop_inject_o), .mem_we_o(mwe),
        .mem_addr_o(maddr), .mem_wdata_o(mwd), .default_working_register_we_o(wwe),
        .default_working_register_wa_o(wa), .default_working_register_wdata_o(wwd));
    ccx_far_model ccx_far_model_inst (.clk_i(clk_i), .instr_i(instr_i),
        .default_working_register_rd_a_i(rd_a), .default_working_register_rd_b_i(rd_b), .default_working_register_a_o(ra), .default_working_register_b_o(rb),
        .sp_o(sp), .mem_rd_o(mrd), .mem_we_i(mwe), .mem_addr_i(maddr),
        .mem_wdata_i(mwd), .default_working_register_we_i(wwe), .default_working_register_wa_i(wa),
        .default_working_register_wdata_i(wwd));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp,
            input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : check_val
    task automatic check_cnt(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) begin
            err_total++;
            $display("wrong value %0t: %s %0d not %0d", $time, what, got, exp);
        end
    endtask : check_cnt
    task automatic setr(input logic [3:0] i, input logic [15:0] d);
        ccx_far_model_inst.regs[i] = d;
    endtask : setr
    task automatic setm(input logic [15:0] a, input logic [15:0] d);
        ccx_far_model_inst.mem[a[15:1]] = d;
    endtask : setm
    function automatic logic [15:0] getr(input logic [3:0] i);
        return ccx_far_model_inst.regs[i];
    endfunction : getr
    function automatic logic [15:0] getm(input logic [15:0] a);
        return ccx_far_model_inst.mem[a[15:1]];
    endfunction : getm
    task automatic issue(input logic [23:0] ins);
        @(posedge clk_i);
        #2 instr_i = ins;
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #2 instr_valid_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #2;
    endtask : issue
    // Stack and target expectations come from the call encoding, PC, register values and word two
    task automatic run_call(input logic [23:0] ins, input logic [23:0] pc,
            input logic stack_frame_active_flag, input logic [15:0] wa_v, input logic [15:0] wb_v,
            input logic [15:0] spv, input logic legal, output int cyc);
        logic [23:0] tgt, ret;
        logic clr, nop;
        ret = pc + (ins[23:16] == CCX_OP_CALL ? CCX_RET_DIRECT
                                              : CCX_RET_INDIRECT);
        tgt = {pc[23], 7'h00, wa_v[15:1], 1'b0};
        if (ins[23:16] == CCX_OP_CALL) tgt = {1'b0, instr2_i[6:0], ins[15:0]};
        else if (ins[15]) tgt = {pc[23], wb_v[6:0], wa_v[15:1], 1'b0};
        setr(ins[3:0], wa_v);
        setr(ins[3:0] + 4'h1, wb_v);
        setr(CCX_SP_IDX, spv);
        setm(spv, 16'hA5A5);
        setm(spv + 16'h0002, 16'hA5A5);
        @(posedge clk_i);
        #2 instr_i = ins;
        pc_i = pc;
        sfa_i = stack_frame_active_flag;
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #2 instr_valid_i = 1'b0;
        cyc = 0;
        clr = 1'b0;
        nop = 1'b0;
        while (pc_load_o !== 1'b1 && cyc < 12) begin
            clr |= (sfa_clr_o === 1'b1);
            nop |= (nop_inject_o === 1'b1);
            @(posedge clk_i);
            #2 cyc++;
        end
        clr |= (sfa_clr_o === 1'b1);
        if (!legal) begin
            check_cnt(cyc, 12, "refused call");
            return;
        end
        // On older cores the last push reaches the model one edge after the load
        @(posedge clk_i);
        #2;
        check_val(pc_o, tgt, "target");
        check_val(24'(getm(spv)), {8'h00, ret[15:1],
            new_core_i ? stack_frame_active_flag : ret[0]}, "low word");
        check_val(24'(getm(spv + 16'h0002)), {16'h0000, ret[23:16]},
            "high byte");
        check_val(24'(getr(CCX_SP_IDX)), 24'(spv + 16'h0004), "sp");
        check_val(24'(clr), 24'(new_core_i), "flag clear");
        check_val(24'(nop), 24'h000001, "nop");
    endtask : run_call
    task automatic clr_chk(input logic [23:0] ins, input logic on_reg,
            input logic [15:0] a, input logic [15:0] init,
            input logic [15:0] exp);
        if (on_reg) setr(a[3:0], init);
        else setm(a, init);
        issue(ins);
        check_val(24'(on_reg ? getr(a[3:0]) : getm(a)), 24'(exp), "clear");
    endtask : clr_chk
    initial begin
        #(3000 * 50);
        err_total++;
        give_verdict();
    end
    initial begin
        int cn, co, k, j;
        logic [3:0] s;
        logic [15:0] a;
        void'($urandom(32'h2F8D74E9));
        repeat (6) @(posedge clk_i);
        #2 rst_n_i = 1'b1;
        instr2_i = 24'h000007;
        instr2_valid_i = 1'b1;
        run_call(24'h027A28, 24'h072000, 1'b1, 16'h0, 16'h0, 16'h9004, 1'b1,
            cn);
        instr2_i = 24'h00007F;
        run_call(24'h02FFFE, 24'h000100, 1'b0, 16'h0, 16'h0, 16'h9004, 1'b1,
            k);
        instr2_valid_i = 1'b0;
        run_call(24'h010000, 24'h001002, 1'b1, 16'h1601, 16'h0, 16'h6F00,
            1'b1, k);
        check_cnt(k, cn, "indirect cycles");
        run_call({8'h01, 1'b1, 4'h5, 7'h00, 4'h4}, 24'h826000, 1'b1, 16'h6845,
            16'hFF82, 16'hA268, 1'b1, k);
        check_cnt(k, cn, "long cycles");
        run_call({8'h01, 1'b1, 4'h4, 7'h00, 4'h3}, 24'h002000, 1'b0, 16'h0,
            16'h0, 16'hA268, 1'b0, k);
        new_core_i = 1'b0;
        run_call(24'h010007, 24'h004200, 1'b1, 16'h5500, 16'h0, 16'h6F00,
            1'b1, co);
        check_cnt(cn - co, CCX_CALL_CYC_NEW - CCX_CALL_CYC_OLD,
            "old cycles");
        new_core_i = 1'b1;
        for (int i = 0; i < 12; i++) begin
            j = $urandom % 3;
            s = (j == 2) ? 4'(($urandom % 7) * 2) : 4'($urandom % 15);
            instr2_i = 24'($urandom % 128);
            instr2_valid_i = (j == 0);
            run_call(j == 0 ? {8'h02, 16'($urandom) & 16'hFFFE} : j == 2 ?
                {8'h01, 1'b1, s + 4'h1, 7'h00, s} : {8'h01, 12'h000, s},
                24'($urandom) & 24'hFFFFFE, 1'($urandom), 16'($urandom),
                16'($urandom), (16'($urandom) & 16'h3FFC) | 16'h4000, 1'b1,
                k);
        end
        instr2_valid_i = 1'b0;
        $display("test calls done");
        clr_chk(24'hEF3200, 1'b0, 16'h1200, 16'h8009, 16'h0000);
        clr_chk(24'hEF7201, 1'b0, 16'h1200, 16'h8009, 16'h0009);
        clr_chk(24'hEF7200, 1'b0, 16'h1200, 16'h8009, 16'h8000);
        clr_chk(24'hEF1200, 1'b1, 16'h0000, 16'h1234, 16'h0000);
        clr_chk(24'hEF5200, 1'b1, 16'h0000, 16'h1234, 16'h1200);
        clr_chk(24'hEB4100, 1'b1, 16'h0002, 16'h3333, 16'h3300);
        for (int i = 0; i < 8; i++) begin
            a = 16'($urandom) & 16'h1FFE;
            clr_chk({8'hEF, 3'b001, a[12:0]}, 1'b0, a, 16'($urandom),
                16'h0000);
        end
        for (int m = 0; m < 6; m++) begin
            setr(4'h3, 16'h2300);
            for (int n = 0; n < 3; n++) setm(16'h22FE + 16'(2 * n), 16'h5607);
            a = m == 4 ? 16'h22FE : m == 5 ? 16'h2302 : 16'h2300;
            issue({8'hEB, 2'b00, 3'(m), 4'h3, 7'h00});
            if (m != 0) check_val(24'(getm(a)), 24'h0, "ind clear");
            check_val(24'(getr(4'h3)), m == 0 ? 24'h0 : (m == 2 || m == 4) ?
                24'h22FE : (m == 3 || m == 5) ? 24'h2302 : 24'h2300,
                "pointer");
        end
        $display("test clears done");
        give_verdict();
    end
endmodule : call_and_clear_execute_test
